// ### include/pic_pkg.sv
// package: constants, register map and types of the pwm control and fault block
// Contract
// R1 - each generator status readable raw or masked by its enables
// R2 - six counter events each with own interrupt enable and trigger enable
// R3 - cleared enable bit masks that interrupt or trigger source
// R4 - set enable bit lets that event raise interrupt or trigger
// R5 - period is clock ticks between successive counter-zero pulses
// R6 - period read returns last programmed value, not necessarily active one
// R7 - one pending period; rewriting before update replaces pending value
// R8 - module enable register: one bit per generator and per fault interrupt
// R9 - module status per generator and fault input, raw or masked
// R10 - suppressed outputs forced to fault level during fault; others pass
// R11 - without extended fault feature or level unset, suppressed output low
// R12 - extended fault: per output level selects high or low drive
// R13 - fault level has no effect unless output is suppressed
// R14 - writing one to generator status bit clears it; zero leaves it
// R15 - fault is or of selected sense-adjusted inputs and comparator triggers
// R16 - minimum fault period mode holds fault for configured cycles
// R17 - masked bit is raw and enable; interrupt high while any masked set
// R18 - pending period loads at next counter zero unless immediate mode
package pic_pkg;
  // ==========================================================
  // sizes
  localparam int N_GEN_MAX    = 4;
  localparam int N_FAULT      = 4;
  localparam int N_DCMP       = 8;
  localparam int N_EVT        = 6;
  localparam int ADDR_W       = 8;
  // ==========================================================
  // module register byte offsets
  localparam logic [7:0] OFS_MOD_INTEN   = 8'h00;
  localparam logic [7:0] OFS_MOD_RAW     = 8'h04;
  localparam logic [7:0] OFS_MOD_MASKED  = 8'h08;
  localparam logic [7:0] OFS_FLT_SUPP    = 8'h0c;
  localparam logic [7:0] OFS_FLT_LEVEL   = 8'h10;
  localparam logic [7:0] OFS_FLT_SENSE   = 8'h14;
  // generator windows: base plus gen times stride, word index in low bits
  localparam logic [7:0] OFS_GEN_BASE    = 8'h80;
  localparam logic [2:0] GIDX_CTL        = 3'h0;
  localparam logic [2:0] GIDX_INTEN      = 3'h1;
  localparam logic [2:0] GIDX_RAW        = 3'h2;
  localparam logic [2:0] GIDX_MASKED     = 3'h3;
  localparam logic [2:0] GIDX_PERIOD     = 3'h4;
  localparam logic [2:0] GIDX_COUNT      = 3'h5;
  localparam logic [2:0] GIDX_FLTSEL     = 3'h6;
  localparam logic [2:0] GIDX_MINFLT     = 3'h7;
  // ==========================================================
  // field positions
  localparam int EVT_ZERO     = 0;
  localparam int EVT_LOAD     = 1;
  localparam int EVT_CMPA_UP  = 2;
  localparam int EVT_CMPA_DN  = 3;
  localparam int EVT_CMPB_UP  = 4;
  localparam int EVT_CMPB_DN  = 5;
  localparam int TRIG_POS     = 8;
  localparam int MOD_FLT_POS  = 4;
  // ==========================================================
  // reset values
  localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
  localparam logic [3:0]  RST_SENSE     = 4'h0;
  localparam logic [15:0] RST_PERIOD    = 16'h0000;
  // ==========================================================
  // generator control word
  typedef struct packed {
    logic fault_src_ext;
    logic min_fault_mode;
    logic immediate;
    logic enable;
  } pic_gen_ctl_type;
endpackage

// ### design/pic_gen_timer.sv
// generator period counter with one pending period slot
`timescale 1ns/100ps
module pic_gen_timer #(
  parameter int PERIOD_W = 16
) (
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  input  wire pic_pkg::pic_gen_ctl_type ctl_in,
  input  wire logic                     period_wr_in,
  input  wire logic [PERIOD_W-1:0]      period_data_in,
  output logic      [PERIOD_W-1:0]      period_prog_out,
  output logic      [PERIOD_W-1:0]      count_out,
  output logic                          zero_evt_out,
  output logic                          load_evt_out
);
  // ==========================================================
  // state
  logic [PERIOD_W-1:0] prog_q;
  logic [PERIOD_W-1:0] active_q;
  logic [PERIOD_W-1:0] cnt_q;
  logic [PERIOD_W-1:0] cnt_d;
  logic [PERIOD_W-1:0] active_d;
  logic                pend_q;
  logic                at_zero;
  logic                take_pend;
  logic [PERIOD_W-1:0] reload;

  assign at_zero   = ctl_in.enable && (cnt_q == '0);
  assign take_pend = pend_q && (ctl_in.immediate || at_zero);   // see R18
  assign active_d  = take_pend ? prog_q : active_q;
  assign reload    = (active_d == '0) ? '0 : active_d - 1'b1;   // see R5
  assign cnt_d     = !ctl_in.enable ? '0 : (at_zero ? reload : cnt_q - 1'b1);

  // ==========================================================
  // registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prog_q       <= '0;
      active_q     <= '0;
      pend_q       <= 1'b0;
      cnt_q        <= '0;
      zero_evt_out <= 1'b0;
      load_evt_out <= 1'b0;
    end else begin
      if (period_wr_in) begin
        prog_q <= period_data_in;   // see R7
      end
      pend_q       <= period_wr_in || (pend_q && !take_pend);   // see R7
      active_q     <= active_d;
      cnt_q        <= cnt_d;
      zero_evt_out <= at_zero;   // see R5
      load_evt_out <= ctl_in.enable && (cnt_q == reload) && !at_zero;
    end
  end

  assign period_prog_out = prog_q;   // see R6
  assign count_out       = cnt_q;
endmodule // pic_gen_timer

// ### design/pic_ctl.sv
// pwm interrupt, trigger, period and fault-output control top
`timescale 1ns/100ps
module pic_ctl #(
  parameter int   N_GEN       = 4,
  parameter int   PERIOD_W    = 16,
  parameter int   MINFLT_W    = 16,
  parameter logic EXT_FAULT   = 1'b1
) (
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire logic [7:0]              addr_in,
  input  wire logic [31:0]             wdata_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [31:0]             rdata_out,
  input  wire logic [4*N_GEN-1:0]      cmp_evt_in,
  input  wire logic [2*N_GEN-1:0]      pwm_raw_in,
  input  wire logic [3:0]              fault_input_n,
  input  wire logic [7:0]              dcmp_trig_in,
  output logic      [2*N_GEN-1:0]      pwm_out,
  output logic      [N_GEN-1:0]        gen_irq_out,
  output logic      [N_GEN-1:0]        gen_trig_out,
  output logic      [N_GEN-1:0]        gen_fault_out,
  output logic                         irq_out
);
  // ==========================================================
  // elaboration checks
  if (N_GEN < 1 || N_GEN > pic_pkg::N_GEN_MAX) begin : g_bad_ngen
    $error("N_GEN must be 1 to 4");
  end
  if (PERIOD_W < 2 || PERIOD_W > 32 || MINFLT_W < 1 || MINFLT_W > 32) begin : g_bad_w
    $error("PERIOD_W 2..32 and MINFLT_W 1..32 required");
  end

  localparam int N_OUT = 2 * N_GEN;

  // ==========================================================
  // address decode
  logic       is_gen;
  logic [1:0] gen_sel;
  logic [2:0] gen_idx;
  logic       wr_inten;
  logic       wr_supp;
  logic       wr_level;
  logic       wr_sense;
  logic       rd_mod_raw;

  assign is_gen     = addr_in[7];
  assign gen_sel    = addr_in[6:5];
  assign gen_idx    = addr_in[4:2];
  assign wr_inten   = wr_in && (addr_in == pic_pkg::OFS_MOD_INTEN);
  assign wr_supp    = wr_in && (addr_in == pic_pkg::OFS_FLT_SUPP);
  assign wr_level   = wr_in && (addr_in == pic_pkg::OFS_FLT_LEVEL);
  assign wr_sense   = wr_in && (addr_in == pic_pkg::OFS_FLT_SENSE);
  assign rd_mod_raw = rd_in && (addr_in == pic_pkg::OFS_MOD_RAW);

  // ==========================================================
  // module-level registers
  logic [7:0]       mod_inten_q;
  logic [N_OUT-1:0] supp_q;
  logic [N_OUT-1:0] level_q;
  logic [3:0]       sense_q;
  logic [3:0]       flt_sticky_q;
  logic [3:0]       flt_sticky_d;
  logic [3:0]       flt_adj;

  // sense bit high means the input is active high
  assign flt_adj      = ~(fault_input_n ^ sense_q);   // see R15
  // read of raw status clears fault bits; a new event wins over the clear
  assign flt_sticky_d = (rd_mod_raw ? 4'h0 : flt_sticky_q) | flt_adj;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mod_inten_q  <= 8'h00;
      supp_q       <= '0;
      level_q      <= '0;
      sense_q      <= pic_pkg::RST_SENSE;
    end else begin
      if (wr_inten) begin
        mod_inten_q <= wdata_in[7:0];   // see R8
      end
      if (wr_supp) begin
        supp_q <= wdata_in[N_OUT-1:0];
      end
      if (wr_level) begin
        level_q <= wdata_in[N_OUT-1:0];
      end
      if (wr_sense) begin
        sense_q <= wdata_in[3:0];
      end
    end
  end

  // sticky fault status, cleared by a read of raw status
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flt_sticky_q <= 4'h0;
    end else begin
      flt_sticky_q <= flt_sticky_d;   // see R9
    end
  end

  // ==========================================================
  // per-generator logic
  pic_pkg::pic_gen_ctl_type ctl_q [N_GEN];
  logic [13:0]          inten_q  [N_GEN];
  logic [5:0]           raw_q    [N_GEN];
  logic [11:0]          fsel_q   [N_GEN];
  logic [MINFLT_W-1:0]  minflt_q [N_GEN];
  logic [MINFLT_W-1:0]  fcnt_q   [N_GEN];
  logic [PERIOD_W-1:0]  prog_w   [N_GEN];
  logic [PERIOD_W-1:0]  count_w  [N_GEN];
  logic [N_GEN-1:0]     gen_irq_d;
  logic [N_GEN-1:0]     gen_trig_d;
  logic [N_GEN-1:0]     gen_fault_d;

  for (genvar g = 0; g < N_GEN; g++) begin : g_gen
    logic        hit;
    logic        wr_ctl;
    logic        wr_ien;
    logic        wr_raw;
    logic        wr_per;
    logic        wr_fsel;
    logic        wr_minf;
    logic        zero_evt;
    logic        load_evt;
    logic [5:0]  evt;
    logic [5:0]  raw_d;
    logic [11:0] ftrig;
    logic        cond;
    logic        ext_on;
    logic [MINFLT_W-1:0] fcnt_d;

    assign hit     = wr_in && is_gen && (gen_sel == 2'(g));
    assign wr_ctl  = hit && (gen_idx == pic_pkg::GIDX_CTL);
    assign wr_ien  = hit && (gen_idx == pic_pkg::GIDX_INTEN);
    assign wr_raw  = hit && (gen_idx == pic_pkg::GIDX_RAW);
    assign wr_per  = hit && (gen_idx == pic_pkg::GIDX_PERIOD);
    assign wr_fsel = hit && (gen_idx == pic_pkg::GIDX_FLTSEL);
    assign wr_minf = hit && (gen_idx == pic_pkg::GIDX_MINFLT);

    pic_gen_timer #(
      .PERIOD_W (PERIOD_W)
    ) u_timer (
      .clk_in          (clk_in),
      .nrst_in         (nrst_in),
      .ctl_in          (ctl_q[g]),
      .period_wr_in    (wr_per),
      .period_data_in  (wdata_in[PERIOD_W-1:0]),
      .period_prog_out (prog_w[g]),
      .count_out       (count_w[g]),
      .zero_evt_out    (zero_evt),
      .load_evt_out    (load_evt)
    );

    assign evt   = {cmp_evt_in[4*g+3 -: 4], load_evt, zero_evt};   // see R2
    // write one clears, zero leaves; a same-cycle event keeps its bit
    assign raw_d = (raw_q[g] & ~(wr_raw ? wdata_in[5:0] : 6'h00)) | evt;   // see R14

    // extended selection only when the feature and mode are present
    assign ext_on = EXT_FAULT && ctl_q[g].fault_src_ext;
    assign ftrig  = {dcmp_trig_in, flt_adj} & fsel_q[g];
    assign cond   = ext_on ? |ftrig : flt_adj[0];   // see R15
    // reload while the fault lasts, then count the hold time down
    assign fcnt_d = cond ? minflt_q[g]
                  : ((fcnt_q[g] != '0) ? fcnt_q[g] - 1'b1 : fcnt_q[g]);   // see R16

    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        ctl_q[g]    <= '0;
        inten_q[g]  <= 14'h0000;
        fsel_q[g]   <= 12'h001;
        minflt_q[g] <= '0;
      end else begin
        if (wr_ctl) begin
          ctl_q[g] <= wdata_in[3:0];
        end
        if (wr_ien) begin
          inten_q[g] <= {wdata_in[13:8], 2'h0, wdata_in[5:0]};   // see R3 see R4
        end
        if (wr_fsel) begin
          fsel_q[g] <= wdata_in[11:0];
        end
        if (wr_minf) begin
          minflt_q[g] <= wdata_in[MINFLT_W-1:0];
        end
      end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        raw_q[g] <= 6'h00;
      end else begin
        raw_q[g] <= raw_d;   // see R14
      end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        fcnt_q[g] <= '0;
      end else begin
        fcnt_q[g] <= fcnt_d;   // see R16
      end
    end

    assign gen_irq_d[g]   = |(raw_q[g] & inten_q[g][5:0]);   // see R17 see R3 see R4
    assign gen_trig_d[g]  = |(evt & inten_q[g][13:8]);   // see R3 see R4
    assign gen_fault_d[g] = cond || (ctl_q[g].min_fault_mode && fcnt_q[g] != '0);   // see R16
  end

  // ==========================================================
  // fault output forcing
  logic [N_OUT-1:0] out_fault;
  logic [N_OUT-1:0] eff_level;
  logic [N_OUT-1:0] pwm_d;
  logic [N_OUT-1:0] forced;

  for (genvar o = 0; o < N_OUT; o++) begin : g_out
    assign out_fault[o] = gen_fault_out[o/2];
  end
  assign eff_level = EXT_FAULT ? level_q : '0;   // see R11 see R12
  // level only matters where suppression is set
  assign forced = out_fault & supp_q;   // see R10 see R13
  assign pwm_d  = (forced & eff_level) | (~forced & pwm_raw_in);   // see R10

  // ==========================================================
  // module status
  logic [7:0] mod_raw;
  logic [7:0] mod_masked;

  always_comb begin
    mod_raw = 8'h00;
    mod_raw[N_GEN-1:0] = gen_irq_out;
    mod_raw[7:pic_pkg::MOD_FLT_POS] = flt_sticky_q;   // see R9
  end
  assign mod_masked = mod_raw & mod_inten_q;   // see R9 see R17

  // ==========================================================
  // read mux
  logic [31:0] gen_rd;
  logic [31:0] rd_d;
  logic [1:0]  gs;

  assign gs = (32'(gen_sel) < N_GEN) ? gen_sel : 2'h0;

  always_comb begin
    gen_rd = 32'h0;
    case (gen_idx)
      pic_pkg::GIDX_CTL:    gen_rd[3:0] = ctl_q[gs];
      pic_pkg::GIDX_INTEN:  gen_rd[13:0] = inten_q[gs];   // see R2
      pic_pkg::GIDX_RAW:    gen_rd[5:0] = raw_q[gs];   // see R1
      pic_pkg::GIDX_MASKED: gen_rd[5:0] = raw_q[gs] & inten_q[gs][5:0];   // see R1 see R17
      pic_pkg::GIDX_PERIOD: gen_rd[PERIOD_W-1:0] = prog_w[gs];   // see R6
      pic_pkg::GIDX_COUNT:  gen_rd[PERIOD_W-1:0] = count_w[gs];
      pic_pkg::GIDX_FLTSEL: gen_rd[11:0] = fsel_q[gs];
      pic_pkg::GIDX_MINFLT: gen_rd[MINFLT_W-1:0] = minflt_q[gs];
      default:              gen_rd = 32'h0;
    endcase
  end

  always_comb begin
    rd_d = 32'h0;
    if (!rd_in) begin
      rd_d = 32'h0;
    end else if (is_gen) begin
      rd_d = (32'(gen_sel) < N_GEN) ? gen_rd : 32'h0;
    end else begin
      case (addr_in)
        pic_pkg::OFS_MOD_INTEN:  rd_d[7:0] = mod_inten_q;
        pic_pkg::OFS_MOD_RAW:    rd_d[7:0] = mod_raw;
        pic_pkg::OFS_MOD_MASKED: rd_d[7:0] = mod_masked;
        pic_pkg::OFS_FLT_SUPP:   rd_d[N_OUT-1:0] = supp_q;
        pic_pkg::OFS_FLT_LEVEL:  rd_d[N_OUT-1:0] = level_q;
        pic_pkg::OFS_FLT_SENSE:  rd_d[3:0] = sense_q;
        default:                 rd_d = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // read data register, zero outside the cycle after a read
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= pic_pkg::RST_ZERO;
    end else begin
      rdata_out <= rd_d;   // see R6
    end
  end

  // ==========================================================
  // output flops
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwm_out       <= '0;
      gen_irq_out   <= '0;
      gen_trig_out  <= '0;
      gen_fault_out <= '0;
      irq_out       <= 1'b0;
    end else begin
      pwm_out       <= pwm_d;
      gen_irq_out   <= gen_irq_d;
      gen_trig_out  <= gen_trig_d;
      gen_fault_out <= gen_fault_d;
      irq_out       <= |mod_masked;   // see R17
    end
  end
endmodule // pic_ctl

// ### sim/pic_ctl_chk.sv
// port checker of the pwm control block
`timescale 1ns/100ps
module pic_ctl_chk #(
  parameter int N_GEN = 4
) (
  input wire logic               clk_in,
  input wire logic               nrst_in,
  input wire logic [7:0]         addr_in,
  input wire logic               wr_in,
  input wire logic               rd_in,
  input wire logic [31:0]        rdata_out,
  input wire logic [2*N_GEN-1:0] pwm_raw_in,
  input wire logic [2*N_GEN-1:0] pwm_out,
  input wire logic [N_GEN-1:0]   gen_irq_out,
  input wire logic [N_GEN-1:0]   gen_fault_out,
  input wire logic               irq_out
);
  // ======
  // edges since reset, cycles since last strobe
  logic [1:0] up_q;
  logic [3:0] idle_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      up_q   <= 2'h0;
      idle_q <= 4'hf;
    end else begin
      up_q   <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
      idle_q <= (wr_in || rd_in) ? 4'h0 : ((idle_q == 4'hf) ? idle_q : idle_q + 4'h1);
    end
  end
  // ======
  // properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_read(logic [7:0] a);
    rd_in && addr_in == a;
  endsequence
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not zero outside read");
  a_unmapped_zero: assert property (
    rd_in && addr_in inside {[8'h18:8'h7c]} |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_mod_irq_match: assert property (s_read(8'h08) |=> irq_out == (rdata_out != 32'h0))
    else $error("irq differs from masked status");
  a_gen_irq_match: assert property (s_read(8'h8c)
    |=> gen_irq_out[0] == (rdata_out[5:0] != 6'h0))
    else $error("generator irq differs from masked status");
  a_mod_gen_mirror: assert property (s_read(8'h04)
    |=> rdata_out[N_GEN-1:0] == $past(gen_irq_out))
    else $error("module raw differs from generator irqs");
  a_pwm_pass: assert property (up_q == 2'h3 && $past(gen_fault_out) == '0
    |-> pwm_out == $past(pwm_raw_in))
    else $error("output not passed without fault");
  a_gen_irq_hold: assert property (|($past(gen_irq_out) & ~gen_irq_out)
    |-> idle_q < 4'h5)
    else $error("generator irq dropped without access");
  a_irq_hold: assert property ($fell(irq_out) |-> idle_q < 4'h5)
    else $error("irq dropped without access");
endmodule // pic_ctl_chk

bind pic_ctl pic_ctl_chk #(.N_GEN(N_GEN)) i_chk (.clk_in(clk_in), .nrst_in(nrst_in),
  .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .pwm_raw_in(pwm_raw_in), .pwm_out(pwm_out), .gen_irq_out(gen_irq_out),
  .gen_fault_out(gen_fault_out), .irq_out(irq_out));

// ### sim/pic_stage_model.sv
// power stage model: drives fault pins on trip
`timescale 1ns/100ps
module pic_stage_model (
  input  wire logic [3:0] trip_in,
  input  wire logic [3:0] sense_high_in,
  output logic      [3:0] fault_n_out
);
  // pin level follows the wired sense
  assign fault_n_out = ~(trip_in ^ sense_high_in);
endmodule // pic_stage_model

// ### sim/tb_pic_ctl.sv
// self-checking bench of the pwm control block
`timescale 1ns/100ps
module tb_pic_ctl;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic [15:0] cmp_evt_in = 16'h0;
  logic [7:0]  pwm_raw_in = 8'h00;
  logic [3:0]  fault_input_n;
  logic [7:0]  dcmp_trig_in = 8'h00;
  logic [7:0]  pwm_out;
  logic [3:0]  gen_irq_out;
  logic [3:0]  gen_trig_out;
  logic [3:0]  gen_fault_out;
  logic        irq_out;
  logic [3:0]  trip = 4'h0;
  logic [3:0]  sense = 4'h0;
  logic        seen;
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  localparam logic [7:0] RA [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                                     8'h84, 8'h90, 8'h98, 8'h40};
  always #25 clk_in = ~clk_in;
  pic_ctl i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cmp_evt_in(cmp_evt_in),
    .pwm_raw_in(pwm_raw_in), .fault_input_n(fault_input_n), .dcmp_trig_in(dcmp_trig_in),
    .pwm_out(pwm_out), .gen_irq_out(gen_irq_out), .gen_trig_out(gen_trig_out),
    .gen_fault_out(gen_fault_out), .irq_out(irq_out));
  pic_stage_model i_stage (.trip_in(trip), .sense_high_in(sense), .fault_n_out(fault_input_n));
  // ======
  // tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] act);
    check_count++;
    if (act !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, act);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    chk(name, exp, rdata_out);
  endtask
  task automatic gap(output int len);
    int w;
    w = 0;
    len = 0;
    do begin
      @(posedge clk_in);
      w++;
    end while (gen_trig_out[0] !== 1'b1 && w < 99);
    do begin
      @(posedge clk_in);
      len++;
    end while (gen_trig_out[0] !== 1'b1 && len < 99);
  endtask
  task automatic evt(input int b, output logic s);
    s = 1'b0;
    @(posedge clk_in);
    cmp_evt_in[b] <= 1'b1;
    @(posedge clk_in);
    cmp_evt_in[b] <= 1'b0;
    repeat (3) begin
      @(posedge clk_in);
      s = s | gen_trig_out[0];
    end
  endtask
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  // ======
  // tests
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rc(RA[i], (RA[i] == 8'h98) ? 32'h1 : 32'h0, "reset value");
    end
    $display("test reset done");
    wr(8'h84, 32'h102);
    wr(8'h90, 32'd20);
    wr(8'h80, 32'h1);
    gap(n);
    gap(n);
    chk("period", 32'd20, 32'(n));
    wr(8'h90, 32'd9);
    wr(8'h90, 32'd7);
    rc(8'h90, 32'd7, "period read");
    gap(n);
    chk("period pending", 32'd7, 32'(n));
    wr(8'h80, 32'h3);
    wr(8'h90, 32'd5);
    gap(n);
    gap(n);
    chk("period immediate", 32'd5, 32'(n));
    rc(8'h88, 32'h3, "gen raw");
    rc(8'h8c, 32'h2, "gen masked");
    chk("gen irq", 32'h1, {31'h0, gen_irq_out[0]});
    wr(8'h00, 32'h1);
    tk(3);
    chk("irq on", 32'h1, {31'h0, irq_out});
    rc(8'h04, 32'h1, "mod raw");
    rc(8'h08, 32'h1, "mod masked");
    wr(8'h00, 32'h0);
    rc(8'h08, 32'h0, "mod masked off");
    chk("irq off", 32'h0, {31'h0, irq_out});
    $display("test period done");
    wr(8'h80, 32'h0);
    wr(8'h88, 32'h3f);
    for (int e = 2; e < 6; e++) begin
      wr(8'h84, 32'h101 << e);
      evt(e - 2, seen);
      chk("trig on", 32'h1, {31'h0, seen});
      rc(8'h8c, 32'h1 << e, "masked on");
      wr(8'h88, 32'h3f ^ (32'h1 << e));
      rc(8'h88, 32'h1 << e, "raw kept");
      wr(8'h84, 32'h0);
      rc(8'h8c, 32'h0, "masked off");
      evt(e - 2, seen);
      chk("trig off", 32'h0, {31'h0, seen});
      wr(8'h88, 32'h1 << e);
      rc(8'h88, 32'h0, "raw clear");
    end
    $display("test events done");
    pwm_raw_in <= 8'h0f;
    wr(8'h0c, 32'h3);
    wr(8'h10, 32'h12);
    wr(8'h00, 32'h10);
    trip <= 4'h1;
    tk(4);
    chk("fault gens", 32'hf, {28'h0, gen_fault_out});
    chk("pwm forced", 32'h0e, {24'h0, pwm_out});
    chk("fault irq", 32'h1, {31'h0, irq_out});
    trip <= 4'h0;
    tk(3);
    rc(8'h04, 32'h10, "fault raw");
    rc(8'h04, 32'h0, "fault cleared");
    chk("pwm pass", 32'h0f, {24'h0, pwm_out});
    wr(8'h9c, 32'd6);
    wr(8'h80, 32'h4);
    trip <= 4'h1;
    tk(1);
    trip <= 4'h0;
    n = 0;
    repeat (12) begin
      @(posedge clk_in);
      n += gen_fault_out[0];
    end
    chk("min fault", 32'd7, 32'(n));
    sense <= 4'h2;
    wr(8'h14, 32'h2);
    wr(8'h98, 32'h12);
    wr(8'h80, 32'h8);
    for (int i = 0; i < 3; i++) begin
      dcmp_trig_in <= (i == 0) ? 8'h02 : ((i == 1) ? 8'h01 : 8'h00);
      trip <= (i == 2) ? 4'h2 : 4'h0;
      tk(4);
      chk("ext fault", (i == 0) ? 32'h0 : 32'h1, {31'h0, gen_fault_out[0]});
    end
    $display("test fault done");
    finish_test();
  end
endmodule // tb_pic_ctl
